// *** design/qadc_pkg.sv ***
package qadc_pkg;
	localparam int NUM_CHAN = 4;
	localparam int WORD_BITS = 12;
	// serializer clock is twelve times the sample rate, bit clock six times
	localparam int SER_RATIO = 12;
	localparam int BIT_CLK_RATIO = 6;
	// conversion latency is six whole sample clocks plus one half
	localparam int LATENCY_WHOLE = 6;
	localparam int PIPE_STAGES = LATENCY_WHOLE + 1;
	localparam logic [3:0] LAST_BIT = 4'(SER_RATIO - 1);
	localparam logic [3:0] HALF_FRAME = 4'(SER_RATIO / 2);
	localparam logic [11:0] CODE_ZERO = 12'h000;
	localparam logic [11:0] CODE_FULL = 12'hFFF;
	localparam logic [3:0] BIT_IDX_RESET = 4'h0;

	typedef logic [WORD_BITS-1:0] qadc_word_type;
	typedef struct packed {
		qadc_word_type [NUM_CHAN-1:0] word;
	} qadc_frame_type;
	typedef struct packed {
		logic p;
		logic n;
	} qadc_lvds_type;
endpackage : qadc_pkg

// *** design/qadc_serializer.sv ***
// Summary of operation
// - each channel word on own differential pair
// - all channels sampled on one clock
// - serializer runs on twelve-times clock
// - six-times bit clock, one-times frame clock
// - words go out least significant bit first
// - clocks share the data output path
// - word ready 6.5 sample clocks later
// - straight binary codes, zero to 4095
// - frame clock marks each word start
module qadc_serializer
	import qadc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ser_clk,
	input wire qadc_frame_type conv_code,
	output qadc_lvds_type [NUM_CHAN-1:0] channel_serial_data_out,
	output qadc_lvds_type serial_bit_clock_out,
	output qadc_lvds_type frame_clock_out
);
	// sample clock domain
	qadc_frame_type pipe [PIPE_STAGES];
	qadc_frame_type conv_half;
	qadc_frame_type xfer_word;
	logic xfer_req;
	logic ack_s1;
	logic ack_s2;
	// toggles in the link domain, declared here since the sample side reads it
	logic ser_ack;

	// one sample clock for every channel
	// codes pass straight through, no recoding
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < PIPE_STAGES; i++) begin
				pipe[i] <= '0;
			end
		end else begin
			pipe[0] <= conv_code;
			for (int i = 1; i < PIPE_STAGES; i++) begin
				pipe[i] <= pipe[i-1];
			end
		end
	end

	// falling-edge stage gives the extra half clock
	always_ff @(negedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			conv_half <= '0;
		end else begin
			conv_half <= pipe[PIPE_STAGES-1];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= ser_ack;
			ack_s2 <= ack_s1;
		end
	end

	// word is offered only once the last one was taken; a slow link drops samples
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			xfer_word <= '0;
			xfer_req <= 1'b0;
		end else if (xfer_req == ack_s2) begin
			xfer_word <= conv_half;
			xfer_req <= ~xfer_req;
		end
	end

	// serializer clock domain
	logic ser_rst_s1;
	logic ser_nrst;
	logic req_s1;
	logic req_s2;
	qadc_frame_type cap_word;
	qadc_frame_type shift;
	logic [3:0] bit_idx;

	// word boundary decode, shared by the counter, the shifter and the checks
	function automatic logic is_last_bit(input logic [3:0] idx);
		return idx == LAST_BIT;
	endfunction : is_last_bit

	// reset releases in step with the link clock
	always_ff @(posedge ser_clk or negedge nrst) begin
		if (!nrst) begin
			ser_rst_s1 <= 1'b0;
			ser_nrst <= 1'b0;
		end else begin
			ser_rst_s1 <= 1'b1;
			ser_nrst <= ser_rst_s1;
		end
	end

	always_ff @(posedge ser_clk or negedge ser_nrst) begin
		if (!ser_nrst) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
		end else begin
			req_s1 <= xfer_req;
			req_s2 <= req_s1;
		end
	end

	// xfer_word is held still until the acknowledge returns
	always_ff @(posedge ser_clk or negedge ser_nrst) begin
		if (!ser_nrst) begin
			cap_word <= '0;
			ser_ack <= 1'b0;
		end else if (req_s2 != ser_ack) begin
			cap_word <= xfer_word;
			ser_ack <= req_s2;
		end
	end

	always_ff @(posedge ser_clk or negedge ser_nrst) begin
		if (!ser_nrst) begin
			bit_idx <= BIT_IDX_RESET;
		end else if (is_last_bit(bit_idx)) begin
			bit_idx <= BIT_IDX_RESET;
		end else begin
			bit_idx <= bit_idx + 4'h1;
		end
	end

	// shift right so bit zero leaves first
	always_ff @(posedge ser_clk or negedge ser_nrst) begin
		if (!ser_nrst) begin
			shift <= '0;
		end else if (is_last_bit(bit_idx)) begin
			shift <= cap_word;
		end else begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				shift.word[c] <= shift.word[c] >> 1;
			end
		end
	end

	function automatic qadc_lvds_type diff_pair(input logic b);
		diff_pair.p = b;
		diff_pair.n = ~b;
	endfunction : diff_pair

	// data, bit clock and frame clock leave through one register stage
	// all three are timed by the same bit_idx, so no lane can drift from another
	always_ff @(posedge ser_clk or negedge ser_nrst) begin
		if (!ser_nrst) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				channel_serial_data_out[c] <= diff_pair(1'b0);
			end
		end else begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				channel_serial_data_out[c] <= diff_pair(shift.word[c][0]);
			end
		end
	end

	// bit clock toggles every bit, rising with even bits
	// one data bit per bit clock edge
	always_ff @(posedge ser_clk or negedge ser_nrst) begin
		if (!ser_nrst) begin
			serial_bit_clock_out <= diff_pair(1'b0);
		end else begin
			serial_bit_clock_out <= diff_pair(~bit_idx[0]);
		end
	end

	// frame clock high over the first half of a word
	always_ff @(posedge ser_clk or negedge ser_nrst) begin
		if (!ser_nrst) begin
			frame_clock_out <= diff_pair(1'b0);
		end else begin
			frame_clock_out <= diff_pair(bit_idx < HALF_FRAME);
		end
	end

	// checks
	a_pipe_latency: assert property (@(posedge sys_clk) disable iff (!nrst)
		$past(nrst, 8) |-> conv_half == $past(conv_code, 7))
		else $error("word not ready 6.5 clocks after sampling");

	a_offer_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		(xfer_req != ack_s2) |=> $stable(xfer_word))
		else $error("offered word changed before acknowledge");

	// sample side checks; the pipeline and half stage checks wait one clock out of reset
	a_pipe_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
		$past(nrst) |-> pipe[0] == $past(conv_code))
		else $error("sample not taken on the sample clock");

	a_pipe_advance: assert property (@(posedge sys_clk) disable iff (!nrst)
		$past(nrst) |-> pipe[PIPE_STAGES-1] == $past(pipe[PIPE_STAGES-2]))
		else $error("pipeline skipped a stage");

	a_half_stage: assert property (@(posedge sys_clk) disable iff (!nrst)
		$past(nrst) |-> conv_half == pipe[PIPE_STAGES-1])
		else $error("half clock stage lost its word");

	a_offer_value: assert property (@(posedge sys_clk) disable iff (!nrst)
		(xfer_req == ack_s2) |=> xfer_word == $past(conv_half))
		else $error("offered word is not the latest sample");

	a_offer_toggle: assert property (@(posedge sys_clk) disable iff (!nrst)
		(xfer_req == ack_s2) |=> xfer_req != $past(xfer_req))
		else $error("free link not offered a word");

	a_offer_wait: assert property (@(posedge sys_clk) disable iff (!nrst)
		(xfer_req != ack_s2) |=> xfer_req == $past(xfer_req))
		else $error("new word offered before acknowledge");

	a_bit_clock_rate: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		$past(ser_nrst) |-> serial_bit_clock_out.p != $past(serial_bit_clock_out.p))
		else $error("bit clock missed a toggle");

	a_frame_shape: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		$rose(frame_clock_out.p) |-> ##1 frame_clock_out.p [*5] ##1 !frame_clock_out.p [*6]
		##1 frame_clock_out.p)
		else $error("frame clock not six high then six low");

	a_lsb_first: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		(bit_idx == LAST_BIT) ##1 1'b1 |=> channel_serial_data_out[0].p == $past(cap_word.word[0][0], 2))
		else $error("first bit of a word is not the lsb");

	a_word_load: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		(bit_idx == LAST_BIT) |=> shift == $past(cap_word) && bit_idx == BIT_IDX_RESET)
		else $error("word not loaded at frame boundary");

	a_edge_align: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		$rose(frame_clock_out.p) |-> $rose(serial_bit_clock_out.p))
		else $error("frame start not aligned to bit clock edge");

	a_pair_polarity: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		channel_serial_data_out[3].n == ~channel_serial_data_out[3].p
		&& frame_clock_out.n == ~frame_clock_out.p)
		else $error("differential legs not complementary");

	a_bit_index: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		bit_idx <= LAST_BIT)
		else $error("bit index beyond word length");

	a_code_msb: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		is_last_bit(bit_idx) |-> ##13 channel_serial_data_out[2].p
		== $past(cap_word.word[2][WORD_BITS-1], 13))
		else $error("top code bit not sent last");

	a_cap_take: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		(req_s2 != ser_ack) |=> cap_word == $past(xfer_word))
		else $error("offered word not captured");

	a_cap_ack: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		(req_s2 != ser_ack) |=> ser_ack == $past(req_s2))
		else $error("capture not acknowledged");

	a_cap_hold: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		(req_s2 == ser_ack) |=> $stable(cap_word) && $stable(ser_ack))
		else $error("captured word changed without a request");

	a_shift_step: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		!is_last_bit(bit_idx) |=> shift.word[1] == ($past(shift.word[1]) >> 1))
		else $error("shifter did not move one bit toward the lsb");

	a_data_lane: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		$past(ser_nrst) |-> channel_serial_data_out[1].p == $past(shift.word[1][0]))
		else $error("data pair does not carry its own channel");

	a_lane_pairs: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		channel_serial_data_out[1].n == ~channel_serial_data_out[1].p
		&& channel_serial_data_out[2].n == ~channel_serial_data_out[2].p)
		else $error("data pair legs not complementary");

	a_clock_pair: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		serial_bit_clock_out.n == ~serial_bit_clock_out.p
		&& channel_serial_data_out[0].n == ~channel_serial_data_out[0].p)
		else $error("bit clock legs not complementary");

	a_counter_step: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		!is_last_bit(bit_idx) |=> bit_idx == $past(bit_idx) + 4'h1)
		else $error("bit index skipped a serializer clock");

	a_frame_index: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		$rose(frame_clock_out.p) |-> bit_idx == BIT_IDX_RESET + 4'h1)
		else $error("frame start off the word boundary");

	a_frame_fall: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		$fell(frame_clock_out.p) |-> $rose(serial_bit_clock_out.p))
		else $error("frame midpoint not on a bit clock edge");

	a_frame_period: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		$rose(frame_clock_out.p) |-> ##12 $rose(frame_clock_out.p))
		else $error("frame does not span twelve bit clock edges");

	a_word_first: assert property (@(posedge ser_clk) disable iff (!ser_nrst)
		$rose(frame_clock_out.p)
		|-> channel_serial_data_out[3].p == $past(cap_word.word[3][0], 2))
		else $error("channel three word does not start at its lsb");
endmodule : qadc_serializer

// *** bench/qadc_rx_model.sv ***
module qadc_rx_model
	import qadc_pkg::*;
(
	input wire qadc_lvds_type [NUM_CHAN-1:0] data_in,
	input wire qadc_lvds_type bit_clk_in,
	input wire qadc_lvds_type frame_in,
	output qadc_frame_type rx_word,
	output int frame_edges
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev_frame = 1'b0;
	int idx = 0;
	int edges = 0;
	qadc_frame_type acc = '0;
	always @(bit_clk_in.p) begin
		// edges coincide with data, so sample a quarter bit in
		#20;
		edges++;
		if (frame_in.p && !prev_frame) begin
			frame_edges = edges - 1;
			edges = 1;
			idx = 0;
		end
		prev_frame = frame_in.p;
		for (int c = 0; c < NUM_CHAN; c++)
			acc.word[c][idx] = data_in[c].p;
		if (idx == WORD_BITS - 1)
			rx_word = acc;
		idx = (idx + 1) % WORD_BITS;
	end
endmodule : qadc_rx_model

// *** bench/test_quad_adc_output_serializer.sv ***
module test_quad_adc_output_serializer
	import qadc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic ser_clk = 1'b0;
	logic nrst = 1'b0;
	qadc_frame_type conv_code = '0;
	qadc_lvds_type [NUM_CHAN-1:0] dout;
	qadc_lvds_type bclk;
	qadc_lvds_type fclk;
	qadc_frame_type rx_word;
	int frame_edges;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	always #50 sys_clk = ~sys_clk;
	// link clock phase unrelated to sample clock
	initial #13 forever #40 ser_clk = ~ser_clk;
	qadc_serializer i_qadc_serializer (.sys_clk(sys_clk), .nrst(nrst), .ser_clk(ser_clk),
		.conv_code(conv_code), .channel_serial_data_out(dout),
		.serial_bit_clock_out(bclk), .frame_clock_out(fclk));
	qadc_rx_model i_qadc_rx_model (.data_in(dout), .bit_clk_in(bclk), .frame_in(fclk),
		.rx_word(rx_word), .frame_edges(frame_edges));
	task automatic check(input logic [11:0] seen, input logic [11:0] want);
		comparisons++;
		if (seen !== want) begin
			n_fail++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic test_done();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done
	function automatic qadc_word_type want_word(qadc_frame_type f, int c);
		return f.word[c];
	endfunction : want_word
	// held for many samples since the handshake may skip some
	task automatic run_frame(input qadc_frame_type f);
		@(negedge sys_clk);
		conv_code = f;
		repeat (50) @(negedge sys_clk);
		for (int c = 0; c < NUM_CHAN; c++) begin
			check(rx_word.word[c], want_word(f, c));
			check(12'(dout[c].n), 12'(!dout[c].p));
		end
		check(12'(frame_edges), 12'(SER_RATIO));
		$display("test %h done", f);
	endtask : run_frame
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		qadc_frame_type f;
		void'($urandom(32'h565A));
		repeat (12) @(negedge sys_clk);
		nrst = 1'b1;
		// corners: zero, full scale, distinct channels
		run_frame({NUM_CHAN{CODE_ZERO}});
		run_frame({NUM_CHAN{CODE_FULL}});
		run_frame({12'h001, 12'h800, 12'h555, 12'hAAA});
		repeat (8) begin
			f = 48'({$urandom, $urandom});
			run_frame(f);
		end
		test_done();
	end
endmodule : test_quad_adc_output_serializer
